// *** rtl/cfg_fuse_defines.svh ***
// constants for the configuration and lock fuse block
`ifndef CFG_FUSE_DEFINES_SVH
`define CFG_FUSE_DEFINES_SVH
// ==========================================================
// address map
`define SIG_ADDR_0        16'hFC30
`define SIG_ADDR_1        16'hFC31
`define SIG_ADDR_2        16'hFC60
`define CUST_ADDR_LO      16'hFCE0
`define CUST_ADDR_HI      16'hFCFF
`define CFG1_ADDR         16'hFD00
`define CFG2_ADDR         16'hFD01
// ==========================================================
// field positions in config byte one
`define CFG1_WDT_BIT      7
`define CFG1_PRST_BIT     5
`define CFG1_OSC_MSB      2
`define CFG1_OSC_LSB      0
// ==========================================================
// reset, unprogrammed and signature values
`define FUSE_BLANK        8'hFF
`define OSC_EXTERNAL      3'h7
`define SIG_BYTE_0        8'h15  // arbitrary value
`define SIG_BYTE_1        8'h2A  // arbitrary value
`define SIG_BYTE_2        8'h3C  // arbitrary value
`endif

// *** rtl/cfg_fuse_pkg.sv ***
// types for the configuration and lock fuse block
package cfg_fuse_pkg;
   // lock state from the two lock bits (second, first)
   typedef enum logic [1:0] {
      LOCK_OPEN   = 2'b11,
      LOCK_PROG   = 2'b10,
      LOCK_BAD    = 2'b01,
      LOCK_FULL   = 2'b00
   } lock_state_t;
   // loader phase, gray along the path
   typedef enum logic [1:0] {
      PH_RESET    = 2'b00,
      PH_LOAD     = 2'b01,
      PH_RUN      = 2'b11
   } phase_t;
endpackage

// *** rtl/fuse_if.sv ***
// carrier between the fuse block and its fuse array
`timescale 1ns/1ps
interface fuse_if;
   logic       we;      // program strobe
   logic [5:0] waddr;   // program word index
   logic [7:0] wdata;   // program data
   logic [5:0] raddr;   // read word index
   logic [7:0] rdata;   // registered read data
   modport ctrl (output we, output waddr, output wdata,
                 output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata,
                 input raddr, output rdata);
endinterface

// *** rtl/fuse_array.sv ***
// small fuse array: 32 customer bytes plus two config bytes
`timescale 1ns/1ps
module fuse_array #(
   parameter int DEPTH = 34
) (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic resetn_i,
   // access port
   fuse_if.mem       fb
);
   `include "cfg_fuse_defines.svh"
   // ==========================================================
   // storage, blank reads ones; one-time cells only clear bits
   // blank fill at declaration, a one-time part arrives unprogrammed
   logic [7:0] mem_r [DEPTH] = '{default: `FUSE_BLANK};
   logic [7:0] rdata_r;   // read data register
   always_ff @(posedge core_clk_i) begin
      if (fb.we && (int'(fb.waddr) < DEPTH)) begin
         mem_r[fb.waddr] <= mem_r[fb.waddr] & fb.wdata;
      end
      if (!resetn_i) begin
         rdata_r <= `FUSE_BLANK;
      end else if (int'(fb.raddr) < DEPTH) begin
         rdata_r <= mem_r[fb.raddr];
      end else begin
         rdata_r <= `FUSE_BLANK;
      end
   end
   assign fb.rdata = rdata_r;
endmodule // fuse_array

// *** rtl/cfg_fuse.sv ***
// configuration and lock fuse loader with read paths
`timescale 1ns/1ps
module cfg_fuse (
   // clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     resetn_i,
   // core code-space data read
   input  wire logic                     code_rd_i,
   input  wire logic [15:0]              code_addr_i,
   output logic                          code_hit_o,
   output logic [7:0]                    code_data_o,
   // core external-data read
   input  wire logic                     xdata_rd_i,
   input  wire logic [15:0]              xdata_addr_i,
   output logic                          xdata_hit_o,
   output logic [7:0]                    xdata_data_o,
   // programmer port
   input  wire logic                     prog_mode_i,
   input  wire logic                     prog_wr_i,
   input  wire logic                     prog_rd_i,
   input  wire logic [15:0]              prog_addr_i,
   input  wire logic [7:0]               prog_wdata_i,
   input  wire logic                     prog_lock_first_i,
   input  wire logic                     prog_lock_second_i,
   output logic                          prog_ack_o,
   output logic                          prog_deny_o,
   output logic [7:0]                    prog_rdata_o,
   output logic                          code_prog_en_o,
   output logic                          code_verify_en_o,
   // decoded configuration
   output logic                          port_reset_level_o,
   output logic                          watchdog_fuse_enable_o,
   output logic [2:0]                    osc_source_select_o,
   output logic [7:0]                    power_up_config_byte_two_o,
   output cfg_fuse_pkg::lock_state_t     lock_state_o,
   output logic                          cfg_valid_o
);
   import cfg_fuse_pkg::*;
   `include "cfg_fuse_defines.svh"

   fuse_if fb ();
   fuse_array #(.DEPTH(34)) u_arr (
      .core_clk_i (core_clk_i),
      .resetn_i   (resetn_i),
      .fb         (fb)
   );

   // ==========================================================
   // address decode helpers
   function automatic logic in_cust(input logic [15:0] a);
      in_cust = (a >= `CUST_ADDR_LO) && (a <= `CUST_ADDR_HI);
   endfunction
   function automatic logic [5:0] fuse_idx(input logic [15:0] a);
      // customer bytes 0..31, config one 32, config two 33
      if (in_cust(a)) fuse_idx = {1'b0, a[4:0]};
      else if (a == `CFG1_ADDR) fuse_idx = 6'h20;
      else if (a == `CFG2_ADDR) fuse_idx = 6'h21;
      else fuse_idx = 6'h3F;
   endfunction
   function automatic logic is_fuse(input logic [15:0] a);
      is_fuse = in_cust(a) || (a == `CFG1_ADDR) || (a == `CFG2_ADDR);
   endfunction

   // ==========================================================
   // state
   typedef struct packed {
      phase_t      ph;
      logic [7:0]  cfg1;
      logic [7:0]  cfg2;
      logic        lk1;       // first lock, 0 = programmed
      logic        lk2;       // second lock, 0 = programmed
      logic        chit;
      logic [7:0]  cdat;
      logic        rd_pend;   // array read in flight for core
      logic        xhit;
      logic [7:0]  xdat;
      logic        ack;
      logic        deny;
      logic [7:0]  prd;
      logic        prd_pend;  // array read in flight for programmer
      logic        prst;
      logic        pen;       // code programming allowed
      logic        ven;       // code verify allowed
   } st_t;
   // lock cells and enables start unprogrammed before the first reset
   st_t s_r = st_t'({PH_RESET, `FUSE_BLANK, `FUSE_BLANK, 2'b11,
                     31'h0, 2'b11});
   st_t s_nxt;
   logic [5:0] raddr_nxt;  // array read index
   logic       valid_r;    // load finished, registered

   // ==========================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      raddr_nxt = 6'h3F;
      s_nxt.chit = 1'b0;
      s_nxt.xhit = 1'b0;
      s_nxt.ack = 1'b0;
      s_nxt.deny = 1'b0;
      s_nxt.rd_pend = 1'b0;
      s_nxt.prd_pend = 1'b0;
      case (s_r.ph)
         PH_RESET: begin
            raddr_nxt = 6'h20;
            s_nxt.ph = PH_LOAD;
         end
         PH_LOAD: begin
            // latch once after each reset, not reloaded while running
            s_nxt.cfg1 = fb.rdata;
            s_nxt.prst = fb.rdata[`CFG1_PRST_BIT];
            raddr_nxt = 6'h21;
            s_nxt.ph = PH_RUN;
         end
         PH_RUN: begin
            if (s_r.rd_pend && !s_r.prd_pend) begin
               s_nxt.chit = 1'b1;
               s_nxt.cdat = fb.rdata;
            end
            if (s_r.prd_pend) begin
               s_nxt.ack = 1'b1;
               s_nxt.prd = fb.rdata;
            end
            // second config byte, read during load, lands once
            if (!valid_r) begin
               s_nxt.cfg2 = fb.rdata;
            end
            // programmer side, gated by lock bits
            if (prog_mode_i && prog_wr_i) begin
               if ({s_r.lk2, s_r.lk1} == LOCK_OPEN) begin
                  s_nxt.ack = 1'b1;
               end else begin
                  s_nxt.deny = 1'b1;
               end
            end else if (prog_mode_i && prog_lock_first_i) begin
               s_nxt.lk1 = 1'b0;
               s_nxt.ack = 1'b1;
            end else if (prog_mode_i && prog_lock_second_i) begin
               // second lock only after first
               if (!s_r.lk1) begin
                  s_nxt.lk2 = 1'b0;
                  s_nxt.ack = 1'b1;
               end else begin
                  s_nxt.deny = 1'b1;
               end
            end else if (prog_mode_i && prog_rd_i) begin
               if (s_r.lk1 || s_r.lk2) begin
                  raddr_nxt = fuse_idx(prog_addr_i);
                  s_nxt.prd_pend = 1'b1;
               end else begin
                  s_nxt.deny = 1'b1;
               end
            end else if (code_rd_i) begin
               // signature bytes straight from constants
               if (code_addr_i == `SIG_ADDR_0) begin
                  s_nxt.chit = 1'b1;
                  s_nxt.cdat = `SIG_BYTE_0;
               end else if (code_addr_i == `SIG_ADDR_1) begin
                  s_nxt.chit = 1'b1;
                  s_nxt.cdat = `SIG_BYTE_1;
               end else if (code_addr_i == `SIG_ADDR_2) begin
                  s_nxt.chit = 1'b1;
                  s_nxt.cdat = `SIG_BYTE_2;
               end else if (in_cust(code_addr_i)) begin
                  // data read only, fetch path not decoded
                  raddr_nxt = fuse_idx(code_addr_i);
                  s_nxt.rd_pend = 1'b1;
               end
            end
            // config readback from latched copy
            if (xdata_rd_i && xdata_addr_i == `CFG1_ADDR) begin
               s_nxt.xhit = 1'b1;
               s_nxt.xdat = s_r.cfg1;
            end else if (xdata_rd_i && xdata_addr_i == `CFG2_ADDR) begin
               s_nxt.xhit = 1'b1;
               s_nxt.xdat = s_r.cfg2;
            end
         end
         default: s_nxt.ph = PH_RESET;
      endcase
      if (!resetn_i) begin
         s_nxt = '0;
         s_nxt.ph = PH_RESET;
         s_nxt.cfg1 = `FUSE_BLANK;
         s_nxt.cfg2 = `FUSE_BLANK;
         s_nxt.cdat = 8'h00;
         s_nxt.lk1 = s_r.lk1; // lock cells are nonvolatile
         s_nxt.lk2 = s_r.lk2;
         s_nxt.prst = 1'b1;
         raddr_nxt = 6'h3F;
      end
      // enables follow the lock cells, registered with them
      s_nxt.pen = s_nxt.lk1 & s_nxt.lk2;
      s_nxt.ven = s_nxt.lk1 | s_nxt.lk2;
   end

   // programmer writes reach the array only while open
   assign fb.we = (s_r.ph == PH_RUN) && prog_mode_i && prog_wr_i &&
                  s_r.lk1 && s_r.lk2 && is_fuse(prog_addr_i);
   assign fb.waddr = fuse_idx(prog_addr_i);
   assign fb.wdata = prog_wdata_i;
   assign fb.raddr = raddr_nxt;

   // ==========================================================
   // state register
   always_ff @(posedge core_clk_i) begin
      s_r <= s_nxt;
      valid_r <= resetn_i && (s_r.ph == PH_RUN);
   end

   // ==========================================================
   // outputs, all from flip-flops
   assign cfg_valid_o = valid_r;
   assign code_hit_o = s_r.chit;
   assign code_data_o = s_r.cdat;
   assign xdata_hit_o = s_r.xhit;
   assign xdata_data_o = s_r.xdat;
   assign prog_ack_o = s_r.ack;
   assign prog_deny_o = s_r.deny;
   assign prog_rdata_o = s_r.prd;
   assign code_prog_en_o = s_r.pen;
   assign code_verify_en_o = s_r.ven;
   assign port_reset_level_o = s_r.prst;
   assign watchdog_fuse_enable_o = s_r.cfg1[`CFG1_WDT_BIT];
   assign osc_source_select_o =
      s_r.cfg1[`CFG1_OSC_MSB:`CFG1_OSC_LSB];
   assign power_up_config_byte_two_o = s_r.cfg2;
   assign lock_state_o = lock_state_t'({s_r.lk2, s_r.lk1});

   // ==========================================================
   // checks
   // core code read taken, and the two-cycle customer answer
   sequence core_code_take;
      s_r.ph == PH_RUN && code_rd_i && !prog_mode_i;
   endsequence
   sequence cust_answer;
      ##2 code_hit_o;
   endsequence
   chk_sig_read: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      core_code_take ##0 (code_addr_i == `SIG_ADDR_0) |=>
      (code_hit_o && code_data_o == `SIG_BYTE_0))
      else $error("signature byte not returned");
   chk_cust_read: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      core_code_take ##0 in_cust(code_addr_i) |-> cust_answer)
      else $error("customer read not answered");
   chk_cfg_stable: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      (s_r.ph == PH_RUN && $past(s_r.ph) == PH_RUN) |->
       $stable(s_r.cfg1))
      else $error("config byte changed while running");
   chk_cfg_read: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      (s_r.ph == PH_RUN && xdata_rd_i &&
       xdata_addr_i == `CFG1_ADDR) |=> (xdata_hit_o &&
       xdata_data_o == s_r.cfg1))
      else $error("config byte one readback wrong");
   chk_port_level: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      cfg_valid_o |-> (port_reset_level_o ==
                       s_r.cfg1[`CFG1_PRST_BIT]))
      else $error("port reset level mismatch");
   chk_open_prog: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      (s_r.ph == PH_RUN && prog_mode_i && prog_wr_i &&
       s_r.lk1 && s_r.lk2) |=> prog_ack_o)
      else $error("open part refused programming");
   chk_lock_prog: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      (s_r.ph == PH_RUN && prog_mode_i && prog_wr_i &&
       !s_r.lk1) |=> (prog_deny_o && !prog_ack_o))
      else $error("locked part accepted programming");
   chk_second_lock: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      (s_r.ph == PH_RUN && prog_mode_i && prog_lock_second_i &&
       !prog_wr_i && !prog_lock_first_i && !s_r.lk1) |=>
      (prog_ack_o && lock_state_o == LOCK_FULL))
      else $error("second lock not accepted after first");
   chk_full_verify: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      (s_r.ph == PH_RUN && prog_mode_i && prog_rd_i &&
       !prog_wr_i && !prog_lock_first_i && !prog_lock_second_i &&
       !s_r.lk1 && !s_r.lk2) |=> prog_deny_o)
      else $error("fully locked part allowed verify");
   chk_osc_wdt: assert property (@(posedge core_clk_i)
      disable iff (!resetn_i)
      (s_r.ph == PH_LOAD) |=>
      (osc_source_select_o == $past(fb.rdata[`CFG1_OSC_MSB:`CFG1_OSC_LSB])
       && watchdog_fuse_enable_o == $past(fb.rdata[`CFG1_WDT_BIT])))
      else $error("decoded config fields wrong");
endmodule // cfg_fuse

// *** test/prog_model.sv ***
// programmer partner model driving the fuse block programmer port
`timescale 1ns/1ps
module prog_model (
   // clock
   input  wire logic       core_clk_i,
   // answers from the fuse block
   input  wire logic       prog_ack_i,
   input  wire logic       prog_deny_i,
   input  wire logic [7:0] prog_rdata_i,
   // programmer requests
   output logic            prog_mode_o,
   output logic            prog_wr_o,
   output logic            prog_rd_o,
   output logic            prog_lock_first_o,
   output logic            prog_lock_second_o,
   output logic [15:0]     prog_addr_o,
   output logic [7:0]      prog_wdata_o
);
   // ==========================================================
   // idle levels at time zero
   initial begin
      {prog_mode_o, prog_wr_o, prog_rd_o} = 3'h0;
      {prog_lock_first_o, prog_lock_second_o} = 2'h0;
      prog_addr_o = 16'h0000;
      prog_wdata_o = 8'h00;
   end
   // ==========================================================
   // one request: kind 0 write, 1 first lock, 2 second lock, 3 read
   // second lock goes out alone only when the bench asks for it
   task automatic op(input logic [1:0] kind, input logic [15:0] a,
                     input logic [7:0] d, output logic ack,
                     output logic deny, output logic [7:0] rd);
      int i;
      ack = 1'b0;
      deny = 1'b0;
      rd = 8'h00;
      @(negedge core_clk_i);
      prog_mode_o = 1'b1;
      prog_addr_o = a;
      prog_wdata_o = d;
      case (kind)
         2'd0: prog_wr_o = 1'b1;
         2'd1: prog_lock_first_o = 1'b1;
         2'd2: prog_lock_second_o = 1'b1;
         default: prog_rd_o = 1'b1;
      endcase
      // bounded wait; released lines show the inverse, not stale values
      for (i = 0; i < 5 && !(ack || deny); i++) begin
         @(negedge core_clk_i);
         {prog_wr_o, prog_rd_o} = 2'h0;
         {prog_lock_first_o, prog_lock_second_o} = 2'h0;
         prog_addr_o = ~a;
         prog_wdata_o = ~d;
         ack = (prog_ack_i === 1'b1);
         deny = (prog_deny_i === 1'b1);
         rd = prog_rdata_i;
      end
      prog_mode_o = 1'b0;
   endtask
endmodule // prog_model

// *** test/testbench.sv ***
// self-checking bench for the config and lock fuse block
`timescale 1ns/1ps
`include "cfg_fuse_defines.svh"
module testbench;
   import cfg_fuse_pkg::*;
   // ==========================================================
   // bench signals, named after the design ports
   logic core_clk_i = 1'b0, resetn_i = 1'b0;
   logic code_rd_i = 1'b0, xdata_rd_i = 1'b0;
   logic [15:0] code_addr_i = 16'h0000, xdata_addr_i = 16'h0000;
   logic code_hit_o, xdata_hit_o, prog_ack_o, prog_deny_o, cfg_valid_o;
   logic [7:0] code_data_o, xdata_data_o, prog_rdata_o;
   logic [7:0] power_up_config_byte_two_o;
   logic prog_mode_i, prog_wr_i, prog_rd_i;
   logic prog_lock_first_i, prog_lock_second_i;
   logic [15:0] prog_addr_i;
   logic [7:0] prog_wdata_i;
   logic code_prog_en_o, code_verify_en_o;
   logic port_reset_level_o, watchdog_fuse_enable_o;
   logic [2:0] osc_source_select_o;
   lock_state_t lock_state_o;
   int err_count = 0, comparisons = 0;
   // table row: read kind, address, expected hit and data
   typedef struct { logic xd; logic [15:0] a; logic h; logic [7:0] d; } row_t;
   row_t rows [10] = '{
      '{1'b0, `SIG_ADDR_0, 1'b1, `SIG_BYTE_0},
      '{1'b0, `SIG_ADDR_1, 1'b1, `SIG_BYTE_1},
      '{1'b0, `SIG_ADDR_2, 1'b1, `SIG_BYTE_2},
      '{1'b0, 16'hFC32, 1'b0, 8'h00},
      '{1'b0, `CUST_ADDR_LO, 1'b1, `FUSE_BLANK},
      '{1'b0, `CUST_ADDR_HI, 1'b1, `FUSE_BLANK},
      '{1'b0, `CFG1_ADDR, 1'b0, 8'h00},
      '{1'b1, `CFG1_ADDR, 1'b1, `FUSE_BLANK},
      '{1'b1, `CFG2_ADDR, 1'b1, `FUSE_BLANK},
      '{1'b1, `SIG_ADDR_0, 1'b0, 8'h00}};
   // ==========================================================
   // clock, 10 ns period
   initial forever #5 core_clk_i = ~core_clk_i;
   // ==========================================================
   // device under test and programmer partner
   cfg_fuse cfg_fuse_inst (.core_clk_i, .resetn_i, .code_rd_i,
      .code_addr_i, .code_hit_o, .code_data_o, .xdata_rd_i,
      .xdata_addr_i, .xdata_hit_o, .xdata_data_o, .prog_mode_i,
      .prog_wr_i, .prog_rd_i, .prog_addr_i, .prog_wdata_i,
      .prog_lock_first_i, .prog_lock_second_i, .prog_ack_o,
      .prog_deny_o, .prog_rdata_o, .code_prog_en_o, .code_verify_en_o,
      .port_reset_level_o, .watchdog_fuse_enable_o,
      .osc_source_select_o, .power_up_config_byte_two_o,
      .lock_state_o, .cfg_valid_o);
   prog_model prog_model_inst (.core_clk_i, .prog_ack_i(prog_ack_o),
      .prog_deny_i(prog_deny_o), .prog_rdata_i(prog_rdata_o),
      .prog_mode_o(prog_mode_i), .prog_wr_o(prog_wr_i),
      .prog_rd_o(prog_rd_i), .prog_lock_first_o(prog_lock_first_i),
      .prog_lock_second_o(prog_lock_second_i),
      .prog_addr_o(prog_addr_i), .prog_wdata_o(prog_wdata_i));
   // ==========================================================
   // shared tasks
   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // sync reset held 3 cycles, then bounded wait for the load
   task automatic do_reset;
      int i;
      @(negedge core_clk_i);
      resetn_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
      check("port level in reset", 8'h01, port_reset_level_o);
      resetn_i = 1'b1;
      for (i = 0; i < 6 && cfg_valid_o !== 1'b1; i++)
         @(negedge core_clk_i);
      check("cfg valid", 8'h01, cfg_valid_o);
      if (cfg_valid_o !== 1'b1)
         report_and_stop();
   endtask
   // core read, code or external data; lines inverted when released
   // code reads here are data reads only, never fetches
   task automatic core_rd(input logic xd, input logic [15:0] a,
                          input logic eh, input logic [7:0] ed);
      int i;
      logic h;
      logic [7:0] d;
      h = 1'b0;
      d = 8'h00;
      @(negedge core_clk_i);
      if (xd) {xdata_rd_i, xdata_addr_i} = {1'b1, a};
      else {code_rd_i, code_addr_i} = {1'b1, a};
      for (i = 0; i < 4 && !h; i++) begin
         @(negedge core_clk_i);
         {code_rd_i, xdata_rd_i} = 2'h0;
         code_addr_i = ~a;
         xdata_addr_i = ~a;
         h = xd ? (xdata_hit_o === 1'b1) : (code_hit_o === 1'b1);
         d = xd ? xdata_data_o : code_data_o;
      end
      check("read hit", {7'h00, eh}, {7'h00, h});
      if (eh)
         check("read data", ed, d);
      if (eh && !h)
         report_and_stop();
   endtask
   // programmer request: accepted or refused, read data on accept
   task automatic pop(input logic [1:0] k, input logic [15:0] a,
                      input logic [7:0] d, input logic eack);
      logic ack, deny;
      logic [7:0] rd;
      prog_model_inst.op(k, a, d, ack, deny, rd);
      check("prog ack", {7'h00, eack}, {7'h00, ack});
      check("prog deny", {7'h00, ~eack}, {7'h00, deny});
      if (k == 2'd3 && eack)
         check("prog read data", d, rd);
      if (!(ack || deny))
         report_and_stop();
   endtask
   // ==========================================================
   // main sequence
   initial begin
      do_reset();
      check("osc", {5'h00, `OSC_EXTERNAL}, osc_source_select_o);
      check("wdt", 8'h01, watchdog_fuse_enable_o);
      check("port", 8'h01, port_reset_level_o);
      check("byte two", `FUSE_BLANK, power_up_config_byte_two_o);
      check("lock", LOCK_OPEN, lock_state_o);
      check("prog en", 8'h01, code_prog_en_o);
      check("verify en", 8'h01, code_verify_en_o);
      $display("test blank reset done");
      foreach (rows[i])
         core_rd(rows[i].xd, rows[i].a,
                 rows[i].h, rows[i].d);
      $display("test table done");
      // one pass: customer area and both config bytes with the code
      pop(2'd0, `CUST_ADDR_LO, 8'hA5, 1'b1);
      pop(2'd0, `CUST_ADDR_HI, 8'h5A, 1'b1);
      pop(2'd0, `CFG1_ADDR, 8'h5A, 1'b1);
      pop(2'd0, `CFG2_ADDR, 8'hC3, 1'b1);
      pop(2'd3, `CUST_ADDR_LO, 8'hA5, 1'b1);
      core_rd(1'b0, `CUST_ADDR_LO, 1'b1, 8'hA5);
      core_rd(1'b0, `CUST_ADDR_HI, 1'b1, 8'h5A);
      // new config must not take effect before power up
      core_rd(1'b1, `CFG1_ADDR, 1'b1, `FUSE_BLANK);
      check("osc held", 8'h07, osc_source_select_o);
      check("two held", `FUSE_BLANK, power_up_config_byte_two_o);
      $display("test programming pass done");
      do_reset();
      core_rd(1'b1, `CFG1_ADDR, 1'b1, 8'h5A);
      check("wdt off", 8'h00, watchdog_fuse_enable_o);
      check("port low", 8'h00, port_reset_level_o);
      check("osc code", 8'h02, osc_source_select_o);
      check("two code", 8'hC3, power_up_config_byte_two_o);
      core_rd(1'b1, `CFG2_ADDR, 1'b1, 8'hC3);
      $display("test config reload done");
      // lock sequence, including the refused out-of-order second lock
      pop(2'd2, 16'h0000, 8'h00, 1'b0);
      check("lock open", LOCK_OPEN, lock_state_o);
      pop(2'd1, 16'h0000, 8'h00, 1'b1);
      check("lock prog", LOCK_PROG, lock_state_o);
      check("prog en off", 8'h00, code_prog_en_o);
      check("verify on", 8'h01, code_verify_en_o);
      pop(2'd0, 16'hFCE1, 8'h00, 1'b0);
      pop(2'd3, `CUST_ADDR_LO, 8'hA5, 1'b1);
      pop(2'd2, 16'h0000, 8'h00, 1'b1);
      check("lock full", LOCK_FULL, lock_state_o);
      check("verify off", 8'h00, code_verify_en_o);
      pop(2'd3, `CUST_ADDR_LO, 8'hA5, 1'b0);
      pop(2'd0, `CUST_ADDR_HI, 8'h00, 1'b0);
      do_reset();
      check("lock kept", LOCK_FULL, lock_state_o);
      core_rd(1'b0, `CUST_ADDR_LO, 1'b1, 8'hA5);
      $display("test locks done");
      report_and_stop();
   end
endmodule // testbench
